// ### sacl_activity.sv
// Device activity pin driver with flicker and open-drain mode
module sacl_activity
  import sacl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_busy,
  input wire logic i_open_drain,
  // Pin
  output logic o_pin_out,
  output logic o_pin_oe_n
);
  logic [15:0] cnt_r;
  logic level_r;
  logic wrap;

  assign wrap = (cnt_r == 16'(ACT_HALF_CYC - 1));

  // Flicker while busy, sit low while idle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 16'h0000;
      level_r <= 1'b0;
    end
    else if (!i_busy)
    begin
      cnt_r <= 16'h0000;
      level_r <= 1'b0;
    end
    else
    begin
      cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      level_r <= wrap ? ~level_r : level_r;
    end
  end

  // Open drain only pulls low, so a grounded pin never sources current
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pin_out <= 1'b0;
      o_pin_oe_n <= 1'b0;
    end
    else
    begin
      o_pin_out <= i_open_drain ? 1'b0 : level_r;
      o_pin_oe_n <= i_open_drain & level_r;
    end
  end

  a_od_never_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($past(i_open_drain) && !o_pin_oe_n) |-> !o_pin_out)
    else $error("Open-drain pin driven high");

  a_idle_pin_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_busy ##1 !i_busy) |=> (!o_pin_out && !o_pin_oe_n))
    else $error("Activity pin not low while idle");

endmodule

// ### sacl_cmd_layer.sv
// ATA command layer: task file, decode, DMA-in flow and status FIS
//
// Summary of operation
// - DMA-in command enters prepare state
// - Prepare moves to send-data when data ready
// - Prepare moves to send-status when done or error
// - Each data FIS at most 2048 doublewords
// - Data FIS done returns to prepare
// - Send-status sends Register FIS, interrupt bit set
// - Register FIS sent returns to idle
// - F9h sets maximum address, block addressing allowed
// - CDh and 38h writes without erase decoded
// - F8h reads native maximum, drive bit only
// - Full drive/head usage keeps drive and head
// - Legacy commands and 00h complete as no-op
// - Block addressing only where command supports it
// - Open-drain activity mode never drives high
//
// The placing of the registers and the APB register port are this design's own decisions.
module sacl_cmd_layer
  import sacl_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX_LBA = 28'h0FFFFFF
)
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // Media data source
  output logic O_MEDIA_REQ,
  output logic [27:0] O_MEDIA_LBA,
  input wire logic [31:0] I_MEDIA_DATA,
  input wire logic I_MEDIA_VALID,
  output logic O_MEDIA_READY,
  input wire logic I_MEDIA_ERR,
  // Transport data FIS
  output logic O_TP_DATA_REQ,
  output logic [11:0] O_TP_DATA_LEN,
  output logic [31:0] O_TX_DATA,
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  input wire logic I_TP_DATA_DONE,
  // Transport Register FIS
  output logic O_TP_REG_REQ,
  output logic [7:0] O_TP_REG_STATUS,
  output logic [7:0] O_TP_REG_ERROR,
  output logic O_TP_REG_IBIT,
  output logic [27:0] O_TP_REG_LBA,
  input wire logic I_TP_REG_DONE,
  // Activity indicator pin
  input wire logic I_ACT_IN,
  output logic O_ACT_OUT,
  output logic O_ACT_OE_N
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  sacl_state_t state_r;
  sacl_state_t state_nxt;
  logic [7:0] features_field_r;
  logic [7:0] count_field_r;
  logic [7:0] sector_field_r;
  logic [7:0] cyl_lo_r;
  logic [7:0] cyl_hi_r;
  logic [7:0] drive_head_field_r;
  logic open_drain_r;
  logic [27:0] max_lba_r;
  logic lba_mode_r;
  logic drive_r;
  logic [3:0] head_r;
  logic err_r;
  logic [15:0] remain_r;
  logic [15:0] fis_left_r;
  logic [2:0] act_sync_r;
  logic act_level_r;
  logic fis_req_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state gives registered answers
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic hit;
  logic wr_cmd;
  logic cmd_refused;
  logic [31:0] rd_mux;

  assign apb_access = I_PSEL & I_PENABLE & ~O_PREADY;
  assign apb_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
  assign apb_rd = apb_access & ~I_PWRITE;
  assign hit = (I_PADDR == OFS_FEATURES) | (I_PADDR == OFS_COUNT) |
    (I_PADDR == OFS_SECTOR) | (I_PADDR == OFS_CYL_LO) |
    (I_PADDR == OFS_CYL_HI) | (I_PADDR == OFS_DRIVE_HEAD) |
    (I_PADDR == OFS_COMMAND) | (I_PADDR == OFS_CONFIG) |
    (I_PADDR == OFS_MAX_LBA) | (I_PADDR == OFS_PARAM);
  // Command write while busy is refused so the running command survives
  assign cmd_refused = (I_PADDR == OFS_COMMAND) & I_PWRITE &
    (state_r != ST_IDLE);
  assign wr_cmd = apb_wr & (I_PADDR == OFS_COMMAND) & (state_r == ST_IDLE);

  assign rd_mux =
    (I_PADDR == OFS_FEATURES) ? {24'h000000, features_field_r} :
    (I_PADDR == OFS_COUNT) ? {24'h000000, count_field_r} :
    (I_PADDR == OFS_SECTOR) ? {24'h000000, sector_field_r} :
    (I_PADDR == OFS_CYL_LO) ? {24'h000000, cyl_lo_r} :
    (I_PADDR == OFS_CYL_HI) ? {24'h000000, cyl_hi_r} :
    (I_PADDR == OFS_DRIVE_HEAD) ? {24'h000000, drive_head_field_r} :
    (I_PADDR == OFS_COMMAND) ?
      {16'h0000, O_TP_REG_ERROR, O_TP_REG_STATUS[7:4], act_level_r, err_r,
       state_r} :
    (I_PADDR == OFS_CONFIG) ? {31'h00000000, open_drain_r} :
    (I_PADDR == OFS_MAX_LBA) ? {4'h0, max_lba_r} :
    (I_PADDR == OFS_PARAM) ? {26'h0000000, drive_r, lba_mode_r, head_r} :
    32'h00000000;

  // APB answer flops
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY <= apb_access;
      O_PRDATA <= apb_rd ? rd_mux : 32'h00000000;
      O_PSLVERR <= apb_access & (~hit | cmd_refused);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task file, loaded before the command code
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      features_field_r <= 8'h00;
      count_field_r <= 8'h00;
      sector_field_r <= 8'h00;
      cyl_lo_r <= 8'h00;
      cyl_hi_r <= 8'h00;
      drive_head_field_r <= 8'h00;
      open_drain_r <= CONFIG_OPEN_DRAIN_RST;
    end
    else if (apb_wr && state_r == ST_IDLE)
    begin
      if (I_PADDR == OFS_FEATURES) features_field_r <= I_PWDATA[7:0];
      if (I_PADDR == OFS_COUNT) count_field_r <= I_PWDATA[7:0];
      if (I_PADDR == OFS_SECTOR) sector_field_r <= I_PWDATA[7:0];
      if (I_PADDR == OFS_CYL_LO) cyl_lo_r <= I_PWDATA[7:0];
      if (I_PADDR == OFS_CYL_HI) cyl_hi_r <= I_PWDATA[7:0];
      if (I_PADDR == OFS_DRIVE_HEAD) drive_head_field_r <= I_PWDATA[7:0];
      if (I_PADDR == OFS_CONFIG) open_drain_r <= I_PWDATA[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and parameter usage
  sacl_attr_t attr;
  logic cmd_lba;
  logic [3:0] cmd_head;
  logic [27:0] cmd_addr;
  logic [15:0] cmd_sectors;
  logic [15:0] cmd_dwords;

  assign attr = sacl_decode(I_PWDATA[7:0]);
  // Block mode only when the command allows it
  assign cmd_lba = attr.lba_ok & drive_head_field_r[DH_LBA_BIT];
  // Drive-only commands see head bits as zero
  assign cmd_head = attr.dh_full ? drive_head_field_r[3:0] : 4'h0;
  assign cmd_addr = {cmd_head, cyl_hi_r, cyl_lo_r, sector_field_r};
  // Sector count zero means 256 sectors
  assign cmd_sectors = (count_field_r == 8'h00) ? SECTORS_ZERO :
    {8'h00, count_field_r};
  assign cmd_dwords = 16'(cmd_sectors * DW_PER_SECTOR);

  // Latched parameters, max address and media address
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      lba_mode_r <= 1'b0;
      drive_r <= 1'b0;
      head_r <= 4'h0;
      max_lba_r <= MAX_LBA_RST;
      O_MEDIA_LBA <= 28'h0000000;
    end
    else if (wr_cmd)
    begin
      lba_mode_r <= cmd_lba;
      drive_r <= drive_head_field_r[DH_DRIVE_BIT];
      head_r <= cmd_head;
      O_MEDIA_LBA <= cmd_addr;
      if (I_PWDATA[7:0] == CMD_SET_MAX)
        max_lba_r <= cmd_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command flow state machine; command write starts it
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic fifo_pop;
  logic [5:0] fifo_count;
  logic tx_take;
  logic [15:0] fis_len;

  assign fis_len = (remain_r > FIS_MAX_DW) ? FIS_MAX_DW : remain_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (wr_cmd)
          state_nxt = (attr.known && attr.dma_in) ? ST_PREP : ST_STATUS;
      ST_PREP:
        if (err_r || I_MEDIA_ERR || remain_r == 16'h0000)
          state_nxt = ST_STATUS;
        else if (fifo_valid)
          state_nxt = ST_DATA;
      ST_DATA:
        if (I_TP_DATA_DONE)
          state_nxt = ST_PREP;
      ST_STATUS:
        if (I_TP_REG_DONE)
          state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Error flag: a media error in the very cycle of a new command still counts
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      err_r <= 1'b0;
    else if (wr_cmd)
      err_r <= ~attr.known | I_MEDIA_ERR;
    else if (state_r != ST_IDLE && I_MEDIA_ERR)
      err_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path: media into FIFO, FIFO into a registered TX stage
  assign tx_take = O_TX_VALID & I_TX_READY;
  assign fifo_pop = (state_r == ST_DATA) & (fis_left_r != 16'h0000) &
    fifo_valid & (~O_TX_VALID | I_TX_READY);

  sacl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_in_valid(I_MEDIA_VALID & O_MEDIA_READY),
    .i_in_data(I_MEDIA_DATA),
    .o_in_ready(),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(fifo_pop),
    .o_count(fifo_count)
  );

  // Stop at the request so no stray word waits for the next command
  logic fetch_more;
  assign fetch_more = remain_r >
    16'(fifo_count) + 16'(I_MEDIA_VALID & O_MEDIA_READY);

  // Ready is registered one slot early so it never overfills the FIFO
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_MEDIA_READY <= 1'b0;
      O_MEDIA_REQ <= 1'b0;
    end
    else
    begin
      O_MEDIA_READY <= O_MEDIA_REQ & fetch_more &
        (fifo_count < 6'(FIFO_D - 1));
      O_MEDIA_REQ <= (state_nxt == ST_PREP) | (state_nxt == ST_DATA);
    end
  end

  // Transfer counters and data FIS request
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      remain_r <= 16'h0000;
      fis_left_r <= 16'h0000;
      fis_req_r <= 1'b0;
      O_TP_DATA_LEN <= 12'h000;
    end
    else
    begin
      if (wr_cmd)
        remain_r <= cmd_dwords;
      else if (fifo_pop)
        remain_r <= remain_r - 16'h0001;
      if (state_r == ST_PREP && state_nxt == ST_DATA)
      begin
        fis_left_r <= fis_len;
        O_TP_DATA_LEN <= fis_len[11:0] - 12'h001;
        fis_req_r <= 1'b1;
      end
      else
      begin
        if (fifo_pop)
          fis_left_r <= fis_left_r - 16'h0001;
        if (state_nxt != ST_DATA)
          fis_req_r <= 1'b0;
      end
    end
  end
  assign O_TP_DATA_REQ = fis_req_r;

  // TX stage holds a word until the transport takes it
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_TX_VALID <= 1'b0;
      O_TX_DATA <= 32'h00000000;
    end
    else if (fifo_pop)
    begin
      O_TX_VALID <= 1'b1;
      O_TX_DATA <= fifo_data;
    end
    else if (tx_take)
      O_TX_VALID <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register FIS content, loaded on entry to the status state
  logic enter_status;
  logic abort_now;

  assign enter_status = (state_nxt == ST_STATUS) & (state_r != ST_STATUS);
  assign abort_now = wr_cmd ? ~attr.known : (err_r | I_MEDIA_ERR);

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_TP_REG_REQ <= 1'b0;
      O_TP_REG_STATUS <= STAT_DRDY;
      O_TP_REG_ERROR <= 8'h00;
      O_TP_REG_IBIT <= 1'b0;
      O_TP_REG_LBA <= 28'h0000000;
    end
    else if (enter_status)
    begin
      O_TP_REG_REQ <= 1'b1;
      O_TP_REG_IBIT <= 1'b1;
      O_TP_REG_STATUS <= abort_now ? (STAT_DRDY | STAT_ERR) : STAT_DRDY;
      O_TP_REG_ERROR <= abort_now ? ERR_ABRT : 8'h00;
      if (wr_cmd && I_PWDATA[7:0] == CMD_READ_NATIVE_MAX)
        O_TP_REG_LBA <= NATIVE_MAX_LBA;
      else if (wr_cmd)
        O_TP_REG_LBA <= cmd_addr;
    end
    else if (state_r == ST_STATUS && I_TP_REG_DONE)
    begin
      O_TP_REG_REQ <= 1'b0;
      O_TP_REG_IBIT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity pin: readback synchroniser and driver
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      act_sync_r <= 3'h0;
      act_level_r <= 1'b0;
    end
    else
    begin
      act_sync_r <= {act_sync_r[1:0], I_ACT_IN};
      if (act_sync_r[2] == act_sync_r[1])
        act_level_r <= act_sync_r[2];
    end
  end

  sacl_activity u_act (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_busy(O_MEDIA_REQ),
    .i_open_drain(open_drain_r),
    .o_pin_out(O_ACT_OUT),
    .o_pin_oe_n(O_ACT_OE_N)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_dma_cmd_prep: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (wr_cmd && attr.known && attr.dma_in) |=> state_r == ST_PREP)
    else $error("DMA-in command did not enter prepare");

  a_prep_to_data: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (state_r == ST_PREP && !err_r && !I_MEDIA_ERR && remain_r != 16'h0000
     && fifo_valid) |=> (state_r == ST_DATA && O_TP_DATA_REQ))
    else $error("Ready data did not start a data FIS");

  a_prep_to_status: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (state_r == ST_PREP && (err_r || remain_r == 16'h0000))
    |=> (state_r == ST_STATUS && O_TP_REG_REQ))
    else $error("Finished or failed transfer did not send status");

  a_fis_len_max: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (state_r == ST_DATA) |-> (fis_left_r <= FIS_MAX_DW))
    else $error("Data FIS longer than 2048 doublewords");

  a_data_back: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (state_r == ST_DATA && I_TP_DATA_DONE) |=> (state_r == ST_PREP
     && !O_TP_DATA_REQ))
    else $error("Data FIS done did not return to prepare");

  a_reg_ibit: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    O_TP_REG_REQ |-> (O_TP_REG_IBIT && state_r == ST_STATUS))
    else $error("Register FIS without interrupt bit");

  a_status_idle: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (state_r == ST_STATUS && I_TP_REG_DONE) |=> (state_r == ST_IDLE
     && !O_TP_REG_REQ))
    else $error("Status sent but not idle");

  a_unknown_abort: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N)
    (wr_cmd && !attr.known) |=> (O_TP_REG_ERROR == ERR_ABRT
     && O_TP_REG_STATUS == (STAT_DRDY | STAT_ERR)))
    else $error("Unknown command not aborted");

endmodule

// ### sacl_cmd_layer_bench.sv
// Self-checking bench for the ATA command layer
module sacl_cmd_layer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sacl_pkg::*;
  localparam logic [27:0] NATIVE_MAX = 28'h0123456;
  int seed = 84;
  int err_count = 0;
  int comparisons = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] md = 32'h0;
  logic mv = 1'b0;
  logic merr = 1'b0;
  logic mhold = 1'b0;
  logic dreq_d = 1'b0;
  logic saw_rel = 1'b0;
  logic od_hi = 1'b0;
  logic pready, pslverr, mreq, mrdy, dreq, txv, txr, ddone, se;
  logic rreq, ribit, rdone, aout, aoe_n, act_in;
  logic [31:0] prdata, txd, rd;
  logic [27:0] mlba, rlba, lba_seen;
  logic [11:0] dlen;
  logic [7:0] rstat, rerr;
  logic [31:0] q[$];
  logic [11:0] lens[$];
  // Pull-up on the activity pin
  assign act_in = aoe_n | aout;
  sacl_cmd_layer #(.NATIVE_MAX_LBA(NATIVE_MAX)) i_sacl_cmd_layer (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_MEDIA_REQ(mreq),
    .O_MEDIA_LBA(mlba), .I_MEDIA_DATA(md), .I_MEDIA_VALID(mv),
    .O_MEDIA_READY(mrdy), .I_MEDIA_ERR(merr), .O_TP_DATA_REQ(dreq),
    .O_TP_DATA_LEN(dlen), .O_TX_DATA(txd), .O_TX_VALID(txv),
    .I_TX_READY(txr), .I_TP_DATA_DONE(ddone), .O_TP_REG_REQ(rreq),
    .O_TP_REG_STATUS(rstat), .O_TP_REG_ERROR(rerr), .O_TP_REG_IBIT(ribit),
    .O_TP_REG_LBA(rlba), .I_TP_REG_DONE(rdone), .I_ACT_IN(act_in),
    .O_ACT_OUT(aout), .O_ACT_OE_N(aoe_n));
  sacl_host_model i_sacl_host_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_data_req(dreq), .i_data_len(dlen),
    .i_tx_valid(txv), .o_tx_ready(txr), .o_data_done(ddone),
    .i_reg_req(rreq), .o_reg_done(rdone));
  ////////////////////////////////////////////////////////////
  initial
  begin
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  end
  initial
  begin
    #(60000 * 100);
    err_count++;
    tally_and_finish;
  end
  // Media source offers words only while asked, at a random pace
  always @(posedge clk)
  begin
    if (mv && mrdy)
      q.push_back(md);
    if (!mv || mrdy || !mreq)
    begin
      mv <= mreq && !mhold && ($random(seed) & 32'h1) != 32'h0;
      md <= $random(seed);
    end
  end
  // Watch frames, words and the activity pin
  always @(posedge clk)
  begin
    dreq_d <= dreq;
    if (dreq && !dreq_d)
      lens.push_back(dlen);
    if (txv && txr)
      chk("tx_word", q.size() > 0 ? q.pop_front() : 32'hX, txd);
    if (mreq && aoe_n)
      saw_rel <= 1'b1;
    if (aout)
      od_hi <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] sc,
    input logic [31:0] t);
    apb(1'b1, OFS_COUNT, {24'h0, sc});
    apb(1'b1, OFS_SECTOR, {24'h0, t[7:0]});
    apb(1'b1, OFS_CYL_LO, {24'h0, t[15:8]});
    apb(1'b1, OFS_CYL_HI, {24'h0, t[23:16]});
    apb(1'b1, OFS_DRIVE_HEAD, {24'h0, t[31:24]});
    apb(1'b1, OFS_COMMAND, {24'h0, c});
  endtask
  task automatic fin(input logic [7:0] st, input logic [7:0] er);
    int n;
    n = 0;
    while (rreq !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk("reg_status", {24'h0, st}, {24'h0, rstat});
    chk("reg_error", {24'h0, er}, {24'h0, rerr});
    chk("reg_ibit", 32'h1, {31'h0, ribit});
    lba_seen = rlba;
    n = 0;
    while (rreq !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk("reg_req_drop", 32'h0, {31'h0, rreq});
  endtask
  task tally_and_finish;
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] t, u, e;
    logic [9:0] tbl [8];
    // Kind 0 drive-only, 1 full drive/head, 2 unsupported
    tbl = '{10'h000, 10'h0F8, 10'h1F9, 10'h1CD, 10'h138, 10'h090,
      10'h201, 10'h0E5};
    repeat (11) @(posedge clk);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk("config_rst", {31'h0, CONFIG_OPEN_DRAIN_RST}, rd);
    apb(1'b0, OFS_MAX_LBA, 32'h0);
    chk("max_lba_rst", {4'h0, MAX_LBA_RST}, rd);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, se});
    chk("unmapped_data", 32'h0, rd);
    for (int i = 0; i < 8; i++)
    begin
      t = $random(seed);
      u = $random(seed);
      cmd(tbl[i][7:0], u[7:0], t);
      fin(tbl[i][9] ? 8'h41 : 8'h40, tbl[i][9] ? 8'h04 : 8'h00);
      apb(1'b0, OFS_PARAM, 32'h0);
      e = {26'h0, t[28], t[30] & tbl[i][8], tbl[i][8] ? t[27:24] : 4'h0};
      if (!tbl[i][9])
        chk("param", e, rd);
      if (tbl[i][7:0] == CMD_READ_NATIVE_MAX)
        chk("native_max", {4'h0, NATIVE_MAX}, {4'h0, lba_seen});
      if (tbl[i][7:0] == CMD_SET_MAX)
      begin
        apb(1'b0, OFS_MAX_LBA, 32'h0);
        chk("set_max", {4'h0, t[27:0]}, rd);
      end
    end
    // 17 sectors: one full-size frame and a short tail frame
    t = $random(seed);
    cmd(CMD_READ_DMA, 8'h11, t);
    repeat (2) @(posedge clk);
    chk("media_req", 32'h1, {31'h0, mreq});
    chk("media_lba", {4'h0, t[27:0]}, {4'h0, mlba});
    apb(1'b0, OFS_COMMAND, 32'h0);
    chk("busy_state", 32'h1, {31'h0, rd[0]});
    apb(1'b1, OFS_COMMAND, {24'h0, CMD_NOP});
    chk("busy_refused", 32'h1, {31'h0, se});
    fin(8'h40, 8'h00);
    chk("fis_count", 32'h2, 32'(lens.size()));
    chk("fis_len_a", 32'h7FF, {20'h0, lens[0]});
    chk("fis_len_b", 32'h7F, {20'h0, lens[1]});
    chk("left_words", 32'h0, 32'(q.size()));
    chk("act_flicker", 32'h1, {31'h0, saw_rel});
    chk("act_high", 32'h0, {31'h0, od_hi});
    chk("act_idle", 32'h0, {31'h0, aoe_n});
    apb(1'b0, OFS_COMMAND, 32'h0);
    chk("idle_state", 32'h0, {30'h0, rd[1:0]});
    // Media fault while waiting, pin in push-pull mode
    apb(1'b1, OFS_CONFIG, 32'h0);
    mhold <= 1'b1;
    cmd(CMD_READ_DMA, 8'h01, t);
    repeat (2100) @(posedge clk);
    chk("act_drive", 32'h2, {30'h0, aout, aoe_n});
    @(posedge clk);
    merr <= 1'b1;
    @(posedge clk);
    merr <= 1'b0;
    fin(8'h41, 8'h04);
    tally_and_finish;
  end
endmodule

// ### sacl_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module sacl_fifo
  import sacl_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready,
  // Fill level
  output logic [$clog2(D):0] o_count
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign o_count = wr_ptr_r - rd_ptr_r;
  assign o_in_ready = (o_count != (AW+1)'(D));
  assign o_out_valid = (o_count != '0);
  assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign push = i_in_valid & o_in_ready;
  assign pop = i_out_ready & o_out_valid;

  // Pointers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end

  // Storage needs no reset, empty entries are never read out
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
  end

endmodule

// ### sacl_host_model.sv
// Transport-side model: takes data FIS words, confirms frames
module sacl_host_model
  import sacl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data FIS side
  input wire logic i_data_req,
  input wire logic [11:0] i_data_len,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_data_done,
  // Register FIS side
  input wire logic i_reg_req,
  output logic o_reg_done
);
  int seed = 84;
  logic [12:0] taken_r;
  logic [12:0] take;
  logic req_d_r;
  assign take = {12'h000, i_tx_valid & o_tx_ready};
  ////////////////////////////////////////////////////////////
  // Random stalls; a frame is confirmed only after its last word
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_ready <= 1'b0;
      o_data_done <= 1'b0;
      o_reg_done <= 1'b0;
      taken_r <= 13'h0000;
      req_d_r <= 1'b0;
    end
    else
    begin
      o_tx_ready <= ($random(seed) & 32'h1) != 32'h0;
      taken_r <= o_data_done ? 13'h0000 : taken_r + take;
      o_data_done <= i_data_req && !o_data_done &&
        taken_r == {1'b0, i_data_len} + 13'h0001;
      // Status answered slowly, never in the cycle it appears
      req_d_r <= i_reg_req && !o_reg_done;
      o_reg_done <= req_d_r && i_reg_req && !o_reg_done &&
        ($random(seed) & 32'h1) != 32'h0;
    end
  end
endmodule

// ### sacl_pkg.sv
// Package with constants, types and decode for the ATA command layer
package sacl_pkg;

  // APB byte offsets of the task file and control words
  localparam logic [7:0] OFS_FEATURES = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_SECTOR = 8'h08;
  localparam logic [7:0] OFS_CYL_LO = 8'h0C;
  localparam logic [7:0] OFS_CYL_HI = 8'h10;
  localparam logic [7:0] OFS_DRIVE_HEAD = 8'h14;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1C;
  localparam logic [7:0] OFS_MAX_LBA = 8'h20;
  localparam logic [7:0] OFS_PARAM = 8'h24;

  // Values after reset
  localparam logic CONFIG_OPEN_DRAIN_RST = 1'b1;
  localparam logic [27:0] MAX_LBA_RST = 28'hFFFFFFF;

  // Drive/head field positions
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRIVE_BIT = 4;

  // Command codes that need their own handling
  localparam logic [7:0] CMD_READ_DMA = 8'hC8;
  localparam logic [7:0] CMD_SET_MAX = 8'hF9;
  localparam logic [7:0] CMD_READ_NATIVE_MAX = 8'hF8;
  localparam logic [7:0] CMD_WRITE_MULT_NOERASE = 8'hCD;
  localparam logic [7:0] CMD_WRITE_NOERASE = 8'h38;
  localparam logic [7:0] CMD_NOP = 8'h00;

  // Status and error bits of the Register FIS
  localparam logic [7:0] STAT_DRDY = 8'h40;
  localparam logic [7:0] STAT_ERR = 8'h01;
  localparam logic [7:0] ERR_ABRT = 8'h04;

  // Transfer sizes in doublewords and sectors
  localparam logic [15:0] DW_PER_SECTOR = 16'h0080;
  localparam logic [15:0] SECTORS_ZERO = 16'h0100;
  localparam logic [15:0] FIS_MAX_DW = 16'h0800;

  // Activity flicker timing
  localparam int CLK_MHZ = 10;
  localparam int ACT_HALF_US = 200;
  localparam int ACT_HALF_CYC = ACT_HALF_US * CLK_MHZ;

  // Data buffer shape
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 32;

  // Command flow states, Gray along idle-prepare-data-status
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PREP = 2'h1,
    ST_DATA = 2'h3,
    ST_STATUS = 2'h2
  } sacl_state_t;

  typedef struct packed {
    logic known;
    logic dma_in;
    logic dh_full;
    logic lba_ok;
  } sacl_attr_t;

  // Command set: which codes exist and which fields they use
  function automatic sacl_attr_t sacl_decode(input logic [7:0] code);
    sacl_attr_t a;
    a = '{known: 1'b1, dma_in: 1'b0, dh_full: 1'b0, lba_ok: 1'b0};
    case (code)
      8'hC0, 8'hC4, 8'h20, 8'h40, 8'h41, 8'hF9, 8'h87, 8'hCA, 8'hC5,
      8'hCD, 8'h30, 8'h38:
      begin
        a.dh_full = 1'b1;
        a.lba_ok = 1'b1;
      end
      8'hC8:
      begin
        a.dh_full = 1'b1;
        a.lba_ok = 1'b1;
        a.dma_in = 1'b1;
      end
      8'hE5, 8'h98, 8'h90, 8'hE7, 8'hEC, 8'hE3, 8'h97, 8'hE1, 8'h95,
      8'h00, 8'hE4, 8'hF8, 8'h03, 8'hF6, 8'hF3, 8'hF4, 8'hF5, 8'hF1,
      8'hF2, 8'hEF, 8'hC6, 8'hE6, 8'h99, 8'hB0, 8'hE2, 8'h96, 8'hE0,
      8'h94, 8'hE8:
        a.known = 1'b1;
      default:
        a.known = 1'b0;
    endcase
    return a;
  endfunction

endpackage
